// ==== src/wke_pkg.sv ====
// Constants for the wake event status logic: block offsets, field positions and reset values.
// Assumes the host decodes I/O cycles into single-cycle read and write strobes on mclk.
package wke_pkg;

    // Width of the host I/O address and of the register data.
    localparam int WKE_ADDR_W = 16;
    localparam int WKE_DATA_W = 8;
    localparam int WKE_SRC_N  = 8;

    // Offsets within the wake register block; the block spans offsets 0 to 4.
    localparam logic [2:0] WKE_OFF_SUMMARY    = 3'h0;
    localparam logic [2:0] WKE_OFF_RSVD_ONE   = 3'h1;
    localparam logic [2:0] WKE_OFF_ENABLE     = 3'h2;
    localparam logic [2:0] WKE_OFF_RSVD_THREE = 3'h3;
    localparam logic [2:0] WKE_OFF_SOURCE_ONE = 3'h4;
    localparam int         WKE_BLOCK_SPAN     = 5;

    // Field positions.
    localparam int WKE_BIT_SUMMARY_FLAG = 0;
    localparam int WKE_BIT_ENABLE_FLAG  = 0;
    localparam int WKE_SRC_INFRARED     = 0;
    localparam int WKE_SRC_RING_SECOND  = 1;
    localparam int WKE_SRC_RING_FIRST   = 2;
    localparam int WKE_SRC_KEYBOARD     = 3;
    localparam int WKE_SRC_MOUSE        = 4;
    localparam int WKE_SRC_SPECIFIC_KEY = 5;
    localparam int WKE_SRC_FAN_FIRST    = 6;
    localparam int WKE_SRC_FAN_SECOND   = 7;
    localparam int WKE_FOUR_BIT_PIN_THREE_TWO   = 2;
    localparam int WKE_FOUR_BIT_PIN_THREE_THREE = 3;

    // Reset values, taken on standby power-on; WKE_RST_READ also fills the read data on idle cycles and reserved offsets.
    localparam logic [7:0] WKE_RST_SUMMARY    = 8'h00;
    localparam logic [7:0] WKE_RST_ENABLE     = 8'h00;
    localparam logic [7:0] WKE_RST_SOURCE_ONE = 8'h00;
    localparam logic [7:0] WKE_RST_READ       = 8'h00;

endpackage : wke_pkg

// ==== src/wke_src_if.sv ====
// Interface carrying filtered wake source levels and their rising-edge events.
// Assumes both ends run on mclk; events are single-cycle pulses.
`timescale 1ns/1ps
interface wke_src_if #(
    parameter int N = 8
);
    logic [N-1:0] level;
    logic [N-1:0] rise;

    modport drive (output level, output rise);
    modport take  (input level, input rise);
endinterface : wke_src_if

// ==== src/wke_src_sync.sv ====
// Three-stage synchroniser and agreement filter for the wake source pins.
// Assumes pins are asynchronous to mclk and reset_n is the standby power-on reset.
`timescale 1ns/1ps
module wke_src_sync
    import wke_pkg::*;
#(
    parameter int N = WKE_SRC_N
)(
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic [N-1:0] pins,
    wke_src_if.drive          src
);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] level;
        logic [N-1:0] rise;
    } wke_sync_s;

    wke_sync_s q;
    wke_sync_s next_q;

    // A level is accepted only where stages two and three agree; stage one feeds stage two only.
    always_comb
    begin
        logic [N-1:0] agree;
        agree        = ~(q.s2 ^ q.s3);
        next_q       = q;
        next_q.s1    = pins;
        next_q.s2    = q.s1;
        next_q.s3    = q.s2;
        next_q.level = (agree & q.s2) | (~agree & q.level);
        next_q.rise  = next_q.level & ~q.level;
    end

    // Register the whole state.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign src.level = q.level;
    assign src.rise  = q.rise;

endmodule : wke_src_sync

// ==== src/wke_status.sv ====
// Wake event status block: summary status, output enable, first per-source status register.
// Assumes reset_n is the standby power-on reset; the main power-on reset arrives as an
// mclk-synchronous pulse and host I/O cycles arrive as single-cycle strobes on mclk.
`timescale 1ns/1ps
// Overview of operation
// - Summary flag sets whenever the wake output would assert, whatever the enable.
// - Writing one to the summary flag clears it and releases the wake output.
// - Writing zero to the summary flag leaves it unchanged.
// - Summary register resets to zero only on standby power-on, not other resets.
// - Enable bit zero (default) blocks the wake output; one allows it.
// - Enable register resets to zero only on standby power-on, not other resets.
// - Each source status bit sets on its wake event, ignoring all enables.
// - Source bits: infrared, ring two, ring one, keyboard, mouse, key, fan one, fan two.
// - Writing one clears a source status bit; writing zero leaves it.
// - Source status register resets to zero only on standby power-on.
// - Offsets one and three, and bits seven to one at offsets zero and two, read as zero.
// - Registers decode at fixed offsets from the programmed block base address.
module wke_status
    import wke_pkg::*;
#(
    parameter int ADDR_W = WKE_ADDR_W
)(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] wake_block_base,
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    input  wire logic [7:0]        io_wdata,
    output logic      [7:0]        io_rdata,
    output logic                   io_rvalid,
    input  wire logic              infrared_receiver_source,
    input  wire logic              ring_indicator_second,
    input  wire logic              ring_indicator_first,
    input  wire logic              keyboard_source,
    input  wire logic              mouse_source,
    input  wire logic              specific_key_source,
    input  wire logic              fan_speed_input_first,
    input  wire logic              fan_speed_input_second,
    input  wire logic [7:0]        wake_source_enable,
    input  wire logic              other_wake_event,
    input  wire logic              main_power_on_reset,
    input  wire logic              gpio_pin_three_two_is_input,
    input  wire logic              gpio_pin_three_three_is_input,
    output logic      [1:0]        wake_source_status_four_set,
    output logic      [1:0]        sysmgmt_status_four_set,
    output logic                   wake_request_out_n
);

    typedef struct packed {
        logic       summary;
        logic       enable;
        logic [7:0] source_one;
        logic       out_n;
        logic [7:0] rdata;
        logic       rvalid;
        logic [1:0] four_set;
    } wke_state_s;

    wke_state_s  q;
    wke_state_s  next_q;
    logic [7:0]  pins;
    logic        wr_summary;
    logic        wr_enable;
    logic        wr_source;
    logic        rd_hit;
    logic        summary_set;
    logic [7:0]  write_clear;
    logic [2:0]  rd_off;

    wke_src_if #(.N(WKE_SRC_N)) src ();

    // Offset of an address from the block base, or the span itself when outside the block.
    function automatic logic [2:0] block_offset(input logic [ADDR_W-1:0] addr,
                                                input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] diff;
        diff = addr - base;
        if (diff < ADDR_W'(WKE_BLOCK_SPAN))
            block_offset = diff[2:0];
        else
            block_offset = 3'(WKE_BLOCK_SPAN);
    endfunction : block_offset

    // Gather the source pins in status-bit order.
    always_comb
    begin
        pins                       = '0;
        pins[WKE_SRC_INFRARED]     = infrared_receiver_source;
        pins[WKE_SRC_RING_SECOND]  = ring_indicator_second;
        pins[WKE_SRC_RING_FIRST]   = ring_indicator_first;
        pins[WKE_SRC_KEYBOARD]     = keyboard_source;
        pins[WKE_SRC_MOUSE]        = mouse_source;
        pins[WKE_SRC_SPECIFIC_KEY] = specific_key_source;
        pins[WKE_SRC_FAN_FIRST]    = fan_speed_input_first;
        pins[WKE_SRC_FAN_SECOND]   = fan_speed_input_second;
    end

    wke_src_sync #(.N(WKE_SRC_N)) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .pins    (pins),
        .src     (src)
    );

    // Address decode relative to the programmed base.
    assign wr_summary  = io_wr && (block_offset(io_addr, wake_block_base) == WKE_OFF_SUMMARY);
    assign wr_enable   = io_wr && (block_offset(io_addr, wake_block_base) == WKE_OFF_ENABLE);
    assign wr_source   = io_wr && (block_offset(io_addr, wake_block_base) == WKE_OFF_SOURCE_ONE);
    assign rd_off      = block_offset(io_addr, wake_block_base);
    assign rd_hit      = io_rd && (rd_off != 3'(WKE_BLOCK_SPAN));
    assign write_clear = wr_source ? io_wdata : 8'h00;
    // Any enabled source event or an event from elsewhere in the device requests a wake.
    assign summary_set = (|(src.rise & wake_source_enable)) || other_wake_event;

    // Next state. Sets always win over a write-one clear in the same cycle, so no event is lost.
    // Main power-on only sets the pin flags, and soft and hard resets are not inputs here: only reset_n clears these registers.
    always_comb
    begin
        next_q = q;
        if (summary_set)
            next_q.summary = 1'b1;
        else if (wr_summary && io_wdata[WKE_BIT_SUMMARY_FLAG])
            next_q.summary = 1'b0;
        else
            next_q.summary = q.summary;
        if (wr_enable)
            next_q.enable = io_wdata[WKE_BIT_ENABLE_FLAG];
        next_q.source_one = (q.source_one & ~write_clear) | src.rise;
        // Output is derived from the next flags so it moves in the same edge as they do.
        next_q.out_n = ~(next_q.summary & next_q.enable);
        next_q.rvalid = rd_hit;
        next_q.rdata  = WKE_RST_READ;
        if (rd_hit)
        begin
            case (rd_off)
                WKE_OFF_SUMMARY:    next_q.rdata = {7'h00, q.summary};
                WKE_OFF_ENABLE:     next_q.rdata = {7'h00, q.enable};
                WKE_OFF_SOURCE_ONE: next_q.rdata = q.source_one;
                default:            next_q.rdata = WKE_RST_READ;
            endcase
        end
        // Pins strapped as inputs look like a wake at main power-on; report it as a pulse.
        next_q.four_set = {main_power_on_reset && gpio_pin_three_three_is_input,
                           main_power_on_reset && gpio_pin_three_two_is_input};
    end

    // Standby power-on is the only reset that reaches this state.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q.summary    <= WKE_RST_SUMMARY[WKE_BIT_SUMMARY_FLAG];
            q.enable     <= WKE_RST_ENABLE[WKE_BIT_ENABLE_FLAG];
            q.source_one <= WKE_RST_SOURCE_ONE;
            q.out_n      <= 1'b1;
            q.rdata      <= WKE_RST_READ;
            q.rvalid     <= 1'b0;
            q.four_set   <= 2'h0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign io_rdata                    = q.rdata;
    assign io_rvalid                   = q.rvalid;
    assign wake_request_out_n          = q.out_n;
    assign wake_source_status_four_set = q.four_set;
    assign sysmgmt_status_four_set     = q.four_set;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_summary_sets_on: assert property (
        summary_set |=> q.summary)
        else $error("summary flag missed a wake request");
    a_summary_clear_one: assert property (
        (wr_summary && io_wdata[0] && !summary_set && q.enable) |=> !q.summary && wake_request_out_n)
        else $error("write one did not clear summary and release output");
    a_summary_zero_keeps: assert property (
        (wr_summary && !io_wdata[0] && q.summary) |=> q.summary)
        else $error("write zero changed summary flag");
    a_summary_por_keeps: assert property (
        (main_power_on_reset && !io_wr && !summary_set) |=> q.summary == $past(q.summary))
        else $error("main power-on altered summary flag");
    a_enable_gates_out: assert property (
        !q.enable |-> wake_request_out_n)
        else $error("wake output driven while disabled");
    a_enable_por_keeps: assert property (
        (main_power_on_reset && !io_wr) |=> $stable(q.enable))
        else $error("main power-on altered enable bit");
    a_source_sets_bit: assert property (
        (src.rise != 8'h00) |=> ((q.source_one & $past(src.rise)) == $past(src.rise)))
        else $error("source event not recorded");
    a_source_write_clear: assert property (
        (wr_source && src.rise == 8'h00) |=> (q.source_one & $past(io_wdata)) == 8'h00)
        else $error("write one did not clear source bit");
    a_source_por_keeps: assert property (
        (main_power_on_reset && !io_wr && src.rise == 8'h00) |=> $stable(q.source_one))
        else $error("main power-on altered source status");
    a_reserved_reads_zero: assert property (
        (io_rd && (rd_off == WKE_OFF_RSVD_ONE || rd_off == WKE_OFF_RSVD_THREE))
        |=> io_rvalid && io_rdata == 8'h00)
        else $error("reserved offset read non-zero");
    a_out_follows_flags: assert property (
        (q.summary && q.enable) |-> !wake_request_out_n ##1 (q.summary || wake_request_out_n))
        else $error("wake output not driven with flag and enable");
    a_por_gpio_sets: assert property (
        (main_power_on_reset && gpio_pin_three_two_is_input) |=> wake_source_status_four_set[0])
        else $error("main power-on did not flag input pin");

    c_wake_asserted: cover property (summary_set && q.enable ##1 !wake_request_out_n);
    c_wake_cleared:  cover property (!wake_request_out_n ##1 wr_summary ##1 wake_request_out_n);
    c_source_event:  cover property (src.rise != 8'h00 ##1 q.source_one != 8'h00);
    c_set_on_clear:  cover property (summary_set && wr_summary && io_wdata[0]);
    // A filtered source that goes high and later low again, ready for a fresh event.
    c_source_cycle:  cover property (src.level != 8'h00 ##1 src.level == 8'h00);

endmodule : wke_status

// ==== tb/wke_host_pm.sv ====
// Behavioural model of the host power management logic that receives the wake output.
// Assumes the wake output is an active-low level sampled on mclk.
`timescale 1ns/1ps
module wke_host_pm (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic wake_request_out_n,
    output int        wake_count
);
    logic last_n;

    // Count each new wake request; a held request is counted once, as a chipset would.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            last_n     <= 1'b1;
            wake_count <= 0;
        end
        else
        begin
            last_n <= wake_request_out_n;
            if (last_n && !wake_request_out_n)
                wake_count <= wake_count + 1;
        end
    end
endmodule : wke_host_pm

// ==== tb/wke_status_tb.sv ====
// Self-checking bench for the wake status block, driving its strobe-based register port.
// Assumes the block takes a strobe on a rising edge and answers at that same edge.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module wke_status_tb;
    logic        mclk, reset_n, io_wr, io_rd, io_rvalid, wake_request_out_n;
    logic        other_wake_event, main_power_on_reset;
    logic [15:0] base, io_addr;
    logic [7:0]  io_wdata, io_rdata, src, src_en;
    logic [1:0]  is_in, st4_set, sm4_set;
    int          failures, n_tests, cycles, i, wake_count;

    wke_status uut (.mclk(mclk), .reset_n(reset_n), .wake_block_base(base),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid), .infrared_receiver_source(src[0]),
        .ring_indicator_second(src[1]), .ring_indicator_first(src[2]),
        .keyboard_source(src[3]), .mouse_source(src[4]), .specific_key_source(src[5]),
        .fan_speed_input_first(src[6]), .fan_speed_input_second(src[7]),
        .wake_source_enable(src_en), .other_wake_event(other_wake_event),
        .main_power_on_reset(main_power_on_reset),
        .gpio_pin_three_two_is_input(is_in[0]), .gpio_pin_three_three_is_input(is_in[1]),
        .wake_source_status_four_set(st4_set), .sysmgmt_status_four_set(sm4_set),
        .wake_request_out_n(wake_request_out_n));

    wke_host_pm host (.mclk(mclk), .reset_n(reset_n),
        .wake_request_out_n(wake_request_out_n), .wake_count(wake_count));

    // Free-running clock at 200 MHz.
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Hang guard: the sequence needs well under a thousand cycles.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // One write strobe; the register changes at the edge that takes it.
    task automatic wr(input logic [15:0] off, input logic [7:0] d);
        @(posedge mclk);
        io_wr    <= 1'b1;
        io_addr  <= base + off;
        io_wdata <= d;
        @(posedge mclk);
        io_wr <= 1'b0;
        #1;
    endtask : wr

    // One read strobe; data stands for a single cycle, so it is sampled just after the edge.
    task automatic rd(input logic [15:0] off, input logic [7:0] exp);
        @(posedge mclk);
        io_rd   <= 1'b1;
        io_addr <= base + off;
        @(posedge mclk);
        io_rd <= 1'b0;
        #1;
        `CHK(io_rvalid, 1'b1)
        `CHK(io_rdata, exp)
    endtask : rd

    // Raise one source pin and give the three-flop filter time to report it.
    task automatic raise(input int b);
        @(posedge mclk);
        src <= src | 8'(8'h01 << b);
        repeat (6) @(posedge mclk);
    endtask : raise

    // Drop all pins and keep them low long enough for a fresh event later.
    task automatic drop();
        @(posedge mclk);
        src <= 8'h00;
        repeat (4) @(posedge mclk);
    endtask : drop

    initial
    begin
        {reset_n, io_wr, io_rd, other_wake_event, main_power_on_reset} = 5'h00;
        {io_addr, io_wdata, src, src_en, is_in} = 42'h0;
        base = 16'h0A40;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        for (i = 0; i < 5; i++)
            rd(16'(i), 8'h00);
        `CHK(wake_request_out_n, 1'b1)
        wr(16'h2, 8'hFF);
        rd(16'h2, 8'h01);
        wr(16'h1, 8'hFF);
        wr(16'h3, 8'hFF);
        rd(16'h1, 8'h00);
        rd(16'h3, 8'h00);
        wr(16'h2, 8'h00);
        // Every source sets its own bit; zero writes keep it and a one write clears it.
        for (i = 0; i < 8; i++)
        begin
            raise(i);
            rd(16'h4, 8'(8'h01 << i));
            rd(16'h0, 8'h00);
            wr(16'h4, ~8'(8'h01 << i));
            rd(16'h4, 8'(8'h01 << i));
            wr(16'h4, 8'(8'h01 << i));
            rd(16'h4, 8'h00);
            drop();
        end
        // Summary flag sets with the output gated off, then drives the output once enabled.
        src_en <= 8'h01;
        raise(0);
        rd(16'h0, 8'h01);
        `CHK(wake_request_out_n, 1'b1)
        wr(16'h0, 8'h00);
        rd(16'h0, 8'h01);
        wr(16'h2, 8'h01);
        `CHK(wake_request_out_n, 1'b0)
        wr(16'h0, 8'h01);
        `CHK(wake_request_out_n, 1'b1)
        rd(16'h0, 8'h00);
        wr(16'h4, 8'hFF);
        drop();
        @(posedge mclk);
        other_wake_event <= 1'b1;
        @(posedge mclk);
        other_wake_event <= 1'b0;
        #1;
        `CHK(wake_request_out_n, 1'b0)
        // Main-supply power-on flags only the input pin and clears nothing.
        @(posedge mclk);
        is_in               <= 2'b10;
        main_power_on_reset <= 1'b1;
        @(posedge mclk);
        main_power_on_reset <= 1'b0;
        #1;
        `CHK(st4_set, 2'b10)
        `CHK(sm4_set, 2'b10)
        // The other pin alone, then the flag pulse must be gone one cycle later.
        @(posedge mclk);
        is_in               <= 2'b01;
        main_power_on_reset <= 1'b1;
        @(posedge mclk);
        main_power_on_reset <= 1'b0;
        #1;
        `CHK(st4_set, 2'b01)
        `CHK(sm4_set, 2'b01)
        @(posedge mclk);
        #1;
        `CHK(st4_set, 2'b00)
        `CHK(sm4_set, 2'b00)
        rd(16'h0, 8'h01);
        rd(16'h2, 8'h01);
        `CHK(wake_count, 2)
        // Decoding follows the programmed base; one past the block gives no answer.
        @(posedge mclk);
        io_rd   <= 1'b1;
        io_addr <= base + 16'h5;
        @(posedge mclk);
        io_rd <= 1'b0;
        #1;
        `CHK(io_rvalid, 1'b0)
        @(posedge mclk);
        base <= 16'h0C00;
        rd(16'h2, 8'h01);
        // Standby power-on clears everything.
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd(16'h0, 8'h00);
        rd(16'h2, 8'h00);
        `CHK(wake_request_out_n, 1'b1)
        complete_run();
    end
endmodule : wke_status_tb
